// [aie_pkg.sv]
// Package for the alarm input event unit: constants, register map, delay table.
// Assumes a 125 MHz bus clock; all consumers reference names as aie_pkg::name.
`default_nettype none

package aie_pkg;

    // Register byte offsets.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CFG = 8'h04;
    localparam logic [7:0] ADDR_ACK = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0C;
    localparam logic [7:0] ADDR_PINFO = 8'h10;
    localparam logic [7:0] ADDR_DINFO = 8'h14;
    localparam logic [7:0] ADDR_CNT0 = 8'h20;
    localparam logic [7:0] ADDR_LIM0 = 8'h30;

    // Control register fields.
    localparam int CTRL_DIAG_EN = 0;
    localparam int CTRL_BASE_LSB = 16;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // Per-channel config byte: [2:0] delay, [4:3] edge, [5] alarm, [6] counter,
    // [7] count down.
    localparam int CFG_DLY_LSB = 0;
    localparam int CFG_EDGE_LSB = 3;
    localparam int CFG_ALARM = 5;
    localparam int CFG_CNT = 6;
    localparam int CFG_DOWN = 7;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;

    // Acknowledge register bits.
    localparam int ACK_PROC_DONE = 0;
    localparam int ACK_DIAG_DONE = 1;
    localparam int ACK_ERR_CLR = 2;

    // Delay codes.
    typedef enum logic [2:0] {
        AIE_DLY_NONE, AIE_DLY_100US, AIE_DLY_500US, AIE_DLY_3MS, AIE_DLY_15MS
    } aie_dly_e;

    // Edge selection codes.
    typedef enum logic [1:0] {AIE_EDGE_RISE, AIE_EDGE_FALL, AIE_EDGE_BOTH} aie_edge_e;

    // Delay times in microseconds and derived cycle counts at the bus clock.
    localparam int CLK_MHZ = 125;
    localparam int T_100US = 100;
    localparam int T_500US = 500;
    localparam int T_3MS_US = 3000;
    localparam int T_15MS_US = 15000;
    localparam int CYC_100US = T_100US * CLK_MHZ;
    localparam int CYC_500US = T_500US * CLK_MHZ;
    localparam int CYC_3MS = T_3MS_US * CLK_MHZ;
    localparam int CYC_15MS = T_15MS_US * CLK_MHZ;

    // Diagnostic record constants.
    localparam logic [3:0] MOD_CLASS = 4'b1000;
    localparam int DIAG_LOST_BIT = 6;

endpackage : aie_pkg

`default_nettype wire

// [aie_top.sv]
// Alarm input event unit: four inputs as counters or delayed alarm inputs,
// process alarm and diagnostic escalation, all behind an AHB-Lite slave.
// Assumes inputs already synchronous to hclk and a single-word AHB master.
// Delays are counted in hclk cycles; the defaults assume a 125 MHz clock.
//
// The address map and the AHB-Lite register port were decided locally.
`default_nettype none

module aie_top #(
    // Delay counts are parameters so that a test can shorten them.
    parameter int NCH = 4,
    parameter int CYC_100US = aie_pkg::CYC_100US,
    parameter int CYC_500US = aie_pkg::CYC_500US,
    parameter int CYC_3MS = aie_pkg::CYC_3MS,
    parameter int CYC_15MS = aie_pkg::CYC_15MS
) (
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave port.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Field inputs and event outputs.
    input wire logic [3:0] din,
    output logic proc_alarm,
    output logic diag_alarm,
    output logic diag_going
);

    // Returns the cycle count for a delay code.
    // Codes above the last delay choice map to zero, so a counter mode code
    // never arms the alarm timer by accident.
    // This table is the one place where the delay codes meet the cycle counts; aie_pkg derives those from the clock rate.
    function automatic logic [20:0] dly_cycles(input logic [2:0] code);
        unique case (code)
            3'd1: dly_cycles = 21'(CYC_100US);
            3'd2: dly_cycles = 21'(CYC_500US);
            3'd3: dly_cycles = 21'(CYC_3MS);
            3'd4: dly_cycles = 21'(CYC_15MS);
            default: dly_cycles = 21'd0;
        endcase
    endfunction

    // Registers.
    // Counters and limits are full words so software sees the whole range;
    // timers are as wide as the longest delay needs at the default clock.
    logic [31:0] ctrl_q;
    logic [31:0] cfg_q;
    logic [31:0] cnt_q [NCH];
    logic [31:0] lim_q [NCH];
    logic [3:0] din_q;
    logic [20:0] tmr_q [NCH];
    // Event bookkeeping for the handler handshake.
    logic [3:0] pend_q;
    logic [3:0] hold_q;
    logic proc_q;
    logic [3:0] trig_q;
    logic [3:0] state_q;
    // Diagnostic state; err_q stays set until software clears it.
    logic diag_q;
    logic lost_q;
    logic going_q;
    logic err_q;
    logic [7:0] dinfo_q;

    // AHB address phase capture.
    // The slave never stretches a transfer, so a taken address phase is
    // always followed by its data phase on the next edge.
    logic wr_q;
    logic [7:0] ad_q;
    // A transfer is taken when selected, ready and NONSEQ or SEQ (neither idle nor busy).
    wire take = hsel && hready && htrans[1];

    // Software writes decoded from captured address.
    // Acknowledge bits act only in the data phase, when hwdata stands.
    wire wr_ack = wr_q && ad_q == aie_pkg::ADDR_ACK;
    wire proc_done = wr_ack && hwdata[aie_pkg::ACK_PROC_DONE];
    wire diag_done = wr_ack && hwdata[aie_pkg::ACK_DIAG_DONE];
    wire err_clr = wr_ack && hwdata[aie_pkg::ACK_ERR_CLR];

    // Edge detection on the four inputs.
    // The sampled copy resets to the idle low level, so no false edge
    // appears when reset is released with the inputs low.
    // A pulse shorter than one clock is not seen at all.
    wire [3:0] rise = din & ~din_q;
    wire [3:0] fall = ~din & din_q;

    // Quadrature steps on channel pair 0/1 (A = din[0], B = din[1]).
    // At most one of the eight cases holds per single-track edge; both tracks
    // moving in one cycle raises both terms and is counted as a down step.
    wire q_dn = (rise[1] & ~din[0]) | (fall[1] & din[0]) |
                (rise[0] & din[1]) | (fall[0] & ~din[1]);
    wire q_up = (rise[1] & din[0]) | (fall[1] & ~din[0]) |
                (rise[0] & ~din[1]) | (fall[0] & din[1]);

    // Per-channel events.
    // Each channel owns its config byte, timer, counter and limit; the event
    // bit feeds the shared handler logic below.
    // Channel 0 alone decodes the quadrature pair.
    logic [3:0] evt;
    logic [3:0] qual;
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            wire [7:0] c = cfg_q[8*g +: 8];
            wire is_alarm = c[aie_pkg::CFG_ALARM];
            wire is_cnt = c[aie_pkg::CFG_CNT];
            // Mixed use forces zero delay.
            // A delay would skew the alarm against the count, hence zero.
            wire [20:0] dly = is_cnt ? 21'd0 : dly_cycles(c[2:0]);
            wire [1:0] es = c[aie_pkg::CFG_EDGE_LSB +: 2];
            wire sel_edge = (es == 2'd0 && rise[g]) || (es == 2'd1 && fall[g]) ||
                            (es == 2'd2 && (rise[g] || fall[g]));
            // A new edge starts timing; its level must hold.
            // The timer reads one on the last cycle of the window.
            wire lvl_ok = (tmr_q[g] != 21'd0) && (din[g] == state_q[g]);
            assign qual[g] = is_alarm &&
                ((sel_edge && dly == 21'd0) || (lvl_ok && tmr_q[g] == 21'd1));
            // Counter: quad on ch0 with delay code 7, direction from config otherwise.
            // On reaching a limit the counter restarts from zero.
            // Without a limit it wraps through the full word range.
            wire step = (g == 0 && c[2:0] == 3'd7) ? (q_up | q_dn) : rise[g];
            wire down = (g == 0 && c[2:0] == 3'd7) ? q_dn : c[aie_pkg::CFG_DOWN];
            wire [31:0] nxt = down ? cnt_q[g] - 32'd1 : cnt_q[g] + 32'd1;
            // A hit is a count onto zero downward or onto the set limit.
            wire hit = is_cnt && step && ((down && nxt == 32'd0) ||
                       (lim_q[g] != 32'd0 && nxt == lim_q[g]));
            // Either source raises the same process alarm path.
            assign evt[g] = qual[g] || hit;

            // Counter register.
            // A software write takes precedence over a count step in one cycle.
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    cnt_q[g] <= 32'h0000_0000;
                end else if (wr_q && ad_q == aie_pkg::ADDR_CNT0 + 8'(4 * g)) begin
                    cnt_q[g] <= hwdata;
                end else if (is_cnt && step) begin
                    cnt_q[g] <= (hit && lim_q[g] != 32'd0) ? 32'd0 : nxt;
                end
            end

            // Limit register.
            // Zero means no limit, so the counter wraps freely.
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    lim_q[g] <= 32'h0000_0000;
                end else if (wr_q && ad_q == aie_pkg::ADDR_LIM0 + 8'(4 * g)) begin
                    lim_q[g] <= hwdata;
                end
            end

            // Delay timer: loads on edge, dropped if level leaves early.
            // A selected edge during a running window restarts it, so the
            // alarm always refers to the latest edge.
            // A dropped window stays idle until the next selected edge.
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    tmr_q[g] <= 21'd0;
                end else if (sel_edge && is_alarm && dly != 21'd0) begin
                    tmr_q[g] <= dly;
                end else if (tmr_q[g] != 21'd0 && din[g] != state_q[g]) begin
                    tmr_q[g] <= 21'd0;
                end else if (tmr_q[g] != 21'd0) begin
                    tmr_q[g] <= tmr_q[g] - 21'd1;
                end
            end

            // Level expected after the edge.
            // For both edges the level taken is that of the latest edge.
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    state_q[g] <= 1'b0;
                end else if (sel_edge) begin
                    state_q[g] <= din[g];
                end
            end
        end
    endgenerate

    // Event routing.
    // A recurring event on the channel in service escalates; every other
    // event waits in the pending mask until the handler is free.
    // Escalation is blocked while a diagnostic is already in service.
    // With escalation off, a repeat of the event in service is dropped.
    wire [3:0] same = evt & trig_q & {4{proc_q}};
    wire escalate = ctrl_q[aie_pkg::CTRL_DIAG_EN] && proc_q && |same && !diag_q;
    // A new alarm starts only when no handler of either kind is busy.
    wire [3:0] newev = evt | pend_q;
    wire start_proc = !proc_q && !diag_q && |newev;

    // Input sampling.
    // Inputs are taken as already synchronous, so one flop suffices.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            din_q <= 4'h0;
        end else begin
            din_q <= din;
        end
    end

    // Process alarm handshake; trigger bits latched for the info record.
    // The trigger and state bits of the info record stay frozen until the next alarm
    // starts, so software can read them at any time during its handler.
    // Escalation ends the process alarm because the diagnostic preempts it.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            proc_q <= 1'b0;
            trig_q <= 4'h0;
            hold_q <= 4'h0;
        end else if (start_proc) begin
            proc_q <= 1'b1;
            trig_q <= newev;
            hold_q <= din;
        end else if (escalate || proc_done) begin
            proc_q <= 1'b0;
        end
    end

    // Pending events held while a handler runs; the clear at start wins over a set.
    // Start clears the mask because the new record takes the pending bits.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_q <= 4'h0;
        end else if (start_proc) begin
            pend_q <= 4'h0;
        end else begin
            pend_q <= pend_q | (evt & ~same);
        end
    end

    // Diagnostic alarm, lost flag and going diagnostic.
    // The lost flag sums every event seen while the diagnostic is in
    // service; it is shown in the record once the handler exits.
    // An error clear in the cycle of a new escalation loses to the set.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            diag_q <= 1'b0;
            lost_q <= 1'b0;
            err_q <= 1'b0;
            going_q <= 1'b0;
            dinfo_q <= 8'h00;
        end else begin
            going_q <= 1'b0;
            if (escalate) begin
                diag_q <= 1'b1;
                err_q <= 1'b1;
                lost_q <= 1'b0;
                dinfo_q <= 8'h00;
            end else if (diag_q && diag_done) begin
                diag_q <= 1'b0;
                dinfo_q <= {1'b0, lost_q | (|evt) | (|pend_q), 6'd0};
            end else if (diag_q && |evt) begin
                lost_q <= 1'b1;
            end
            // Going diagnostic only after the incoming handler has exited.
            if (err_q && err_clr && !diag_q && !escalate) begin
                err_q <= 1'b0;
                going_q <= ctrl_q[aie_pkg::CTRL_DIAG_EN];
            end
        end
    end

    // AHB address phase capture; the config registers follow below.
    // The address is captured on every edge; only the write strobe is qualified.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            ad_q <= 8'h00;
        end else begin
            wr_q <= take && hwrite;
            ad_q <= haddr[7:0];
        end
    end

    // Control and configuration; diagnostic data frozen while handled.
    // Configuration writes are dropped while a diagnostic is in service so
    // the reported channel setup cannot change under the handler.
    // Control writes stay open so that escalation can be switched off.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= aie_pkg::CTRL_RESET;
            cfg_q <= aie_pkg::CFG_RESET;
        end else if (wr_q && ad_q == aie_pkg::ADDR_CTRL) begin
            ctrl_q <= hwdata;
        end else if (wr_q && ad_q == aie_pkg::ADDR_CFG && !diag_q) begin
            cfg_q <= hwdata;
        end
    end

    // Read mux; every unmapped address reads zero with OKAY.
    // Decoded from the live address phase so the data is ready one edge later.
    // Limits are write-only to keep the mux small.
    logic [31:0] rdat;
    always_comb begin
        rdat = 32'h0000_0000;
        unique case (haddr[7:0])
            aie_pkg::ADDR_CTRL: rdat = ctrl_q;
            aie_pkg::ADDR_CFG: rdat = cfg_q;
            // Status: lost, error, diagnostic and process flags.
            aie_pkg::ADDR_STAT: rdat = {27'd0, lost_q, err_q, diag_q, proc_q, 1'b0};
            // Word 6 base, byte 9 trigger, byte 11 state.
            aie_pkg::ADDR_PINFO:
                rdat = {4'h0, hold_q, 4'h0, trig_q, ctrl_q[31:16]};
            aie_pkg::ADDR_DINFO:
                rdat = {8'h00, dinfo_q, 6'd0, err_q, err_q,
                        4'h0, aie_pkg::MOD_CLASS};
            // Live counter values.
            aie_pkg::ADDR_CNT0: rdat = cnt_q[0];
            8'h24: rdat = cnt_q[1];
            8'h28: rdat = cnt_q[2];
            8'h2C: rdat = cnt_q[3];
            default: rdat = 32'h0000_0000;
        endcase
    end

    // Read data registered at address phase, outputs from flops.
    // hrdata returns to zero outside a read data phase; the alarm outputs
    // lag the internal state by one cycle.
    // The slave never inserts wait states and never answers with an error.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            proc_alarm <= 1'b0;
            diag_alarm <= 1'b0;
            diag_going <= 1'b0;
        end else begin
            hrdata <= (take && !hwrite) ? rdat : 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            proc_alarm <= proc_q;
            diag_alarm <= diag_q;
            diag_going <= going_q;
        end
    end

endmodule // aie_top

`default_nettype wire

// [aie_chk.sv]
// Checker for the alarm input event unit, watching the top module's ports only.
// Assumes the single slave's hreadyout is fed back as hready by the bus.
`default_nettype none

module aie_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic proc_alarm,
    input wire logic diag_alarm,
    input wire logic diag_going
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // Address phases of reads and writes taken by the slave.
    wire logic rd_req = hsel && htrans[1] && !hwrite;
    wire logic wr_req = hsel && htrans[1] && hwrite;
    // A write to the acknowledge register with bit b set in its data phase.
    sequence ack_wr(int b);
        wr_req && haddr[7:0] == aie_pkg::ADDR_ACK ##1 hwdata[b];
    endsequence
    rdy_high_a: assert property (hreadyout) else $error("Ready went low.");
    resp_okay_a: assert property (!hresp) else $error("Error response seen.");
    going_pulse_a: assert property (diag_going |=> !diag_going)
        else $error("Going pulse longer than one cycle.");
    unmapped_zero_a: assert property (rd_req && haddr[31:8] == 24'h00_0000
        && haddr[7:0] >= 8'h40 |=> hrdata == 32'h0000_0000)
        else $error("Unmapped read not zero.");
    diag_needs_proc_a: assert property ($rose(diag_alarm) |-> $past(proc_alarm))
        else $error("Diagnostic without process alarm.");
    proc_ack_a: assert property (ack_wr(aie_pkg::ACK_PROC_DONE) |-> ##[1:4] !proc_alarm)
        else $error("Process alarm not ended.");
    diag_ack_a: assert property (ack_wr(aie_pkg::ACK_DIAG_DONE) |-> ##[1:4] !diag_alarm)
        else $error("Diagnostic alarm not ended.");
    diag_class_a: assert property (rd_req && haddr[7:0] == aie_pkg::ADDR_DINFO && diag_alarm
        |=> hrdata[3:0] == aie_pkg::MOD_CLASS && hrdata[9:8] == 2'b11)
        else $error("Wrong module class.");
endmodule // aie_chk

bind aie_top aie_chk i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .proc_alarm(proc_alarm),
    .diag_alarm(diag_alarm), .diag_going(diag_going));

`default_nettype wire

// [aie_field.sv]
// Field side model: sensors and encoder tracks on the four digital inputs.
// Assumes the bench calls drive; levels change just after a rising edge.
`default_nettype none

module aie_field (
    input wire logic hclk,
    output logic [3:0] din
);
    timeunit 1ns;
    timeprecision 1ps;
    initial din = 4'h0;
    // Each level stands until the next command, so a held level can qualify.
    task automatic drive(input int ch, input logic lvl);
        @(posedge hclk);
        din[ch] <= lvl;
    endtask
endmodule // aie_field

`default_nettype wire

// [alarm_input_event_unit_test.sv]
// Self-checking bench for the alarm input event unit with shortened delays.
// Assumes aie_pkg, aie_top, aie_chk and aie_field are compiled before it.
`default_nettype none

module alarm_input_event_unit_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0;
    logic hresetn, hsel, hwrite, hit;
    logic [31:0] haddr, hwdata, hrdata, rd_v, first_v;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, proc_alarm, diag_alarm, diag_going;
    wire logic [3:0] din;
    wire logic [2:0] outs = {diag_going, diag_alarm, proc_alarm};
    logic [15:0] base;
    int n_errors = 0;
    int check_count = 0;
    int dly[5] = '{0, 10, 20, 30, 40}; // Delay per code, shortened for the run.
    int trig_q[$]; // Expected trigger masks, in event order.
    int cnt, ch;

    always #4 hclk = ~hclk;

    aie_top #(.CYC_100US(10), .CYC_500US(20), .CYC_3MS(30), .CYC_15MS(40)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .din(din),
        .proc_alarm(proc_alarm), .diag_alarm(diag_alarm), .diag_going(diag_going));
    aie_field i_field (.hclk(hclk), .din(din));

    // Compare and count; a mismatch is reported at once.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // One single AHB-Lite transfer; each phase is held until hready is sampled high.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_v = hrdata;
    endtask
    // Wait a bounded number of cycles for one of the event outputs.
    task automatic await(input int b, input int n);
        hit = 1'b0;
        for (int i = 0; i < n && !hit; i++) begin
            @(posedge hclk);
            #1 hit = (outs[b] === 1'b1);
        end
    endtask
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge hclk);
        n_errors++;
        test_done();
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        void'($urandom(32'h07c1));
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, aie_pkg::ADDR_CTRL, 32'h0000_0000);
        chk(rd_v, aie_pkg::CTRL_RESET);
        bus(1'b0, aie_pkg::ADDR_CFG, 32'h0000_0000);
        chk(rd_v, aie_pkg::CFG_RESET);
        bus(1'b0, 8'h40, 32'h0000_0000);
        chk(rd_v, 32'h0000_0000);
        // Quadruple decode on inputs 0 (A) and 1 (B): four down steps, then eight up.
        bus(1'b1, aie_pkg::ADDR_CFG, 32'h0000_00C7);
        cnt = 0;
        for (int i = 0; i < 12; i++) begin
            if (i < 4) i_field.drive((i % 2 == 0) ? 1 : 0, (i % 4) < 2);
            else i_field.drive((i % 2 == 0) ? 0 : 1, (i % 4) < 2);
            cnt += (i < 4) ? -1 : 1;
            repeat (4) @(posedge hclk);
            if (i == 3 || i == 11) bus(1'b0, aie_pkg::ADDR_CNT0, 32'h0000_0000);
            if (i == 3 || i == 11) chk(rd_v, 32'(cnt));
        end
        base = 16'($urandom);
        bus(1'b1, aie_pkg::ADDR_CTRL, {base, 16'h0000});
        // Every delay code on a random channel, rising edge, level held.
        for (int code = 0; code < 5; code++) begin
            ch = $urandom % 4;
            bus(1'b1, aie_pkg::ADDR_CFG, 32'(8'h20 | code) << (8 * ch));
            trig_q.push_back(1 << ch);
            i_field.drive(ch, 1'b1);
            repeat (dly[code]) @(posedge hclk);
            if (code > 0) chk(32'(proc_alarm), 32'h0000_0000);
            await(0, dly[code] + 10);
            chk(32'(hit), 32'h0000_0001);
            bus(1'b0, aie_pkg::ADDR_PINFO, 32'h0000_0000);
            chk(rd_v, {8'(1 << ch), 8'(trig_q.pop_front()), base});
            i_field.drive(ch, 1'b0);
            bus(1'b1, aie_pkg::ADDR_ACK, 32'h0000_0001);
            repeat (5) @(posedge hclk);
        end
        // Level dropped before the delay ends: nothing is raised.
        bus(1'b1, aie_pkg::ADDR_CFG, 32'h0000_0024);
        i_field.drive(0, 1'b1);
        repeat (20) @(posedge hclk);
        i_field.drive(0, 1'b0);
        repeat (50) @(posedge hclk);
        chk(32'(proc_alarm), 32'h0000_0000);
        // Falling edge selected: the rising edge is ignored, low level qualifies.
        bus(1'b1, aie_pkg::ADDR_CFG, 32'h0000_002C);
        i_field.drive(0, 1'b1);
        repeat (50) @(posedge hclk);
        chk(32'(proc_alarm), 32'h0000_0000);
        i_field.drive(0, 1'b0);
        await(0, 50);
        chk(32'(hit), 32'h0000_0001);
        bus(1'b0, aie_pkg::ADDR_PINFO, 32'h0000_0000);
        chk(rd_v, {8'h00, 8'h01, base});
        bus(1'b1, aie_pkg::ADDR_ACK, 32'h0000_0001);
        // Counter plus alarm on both edges: the 15 ms code is forced to no delay.
        bus(1'b1, aie_pkg::ADDR_CFG, 32'h0000_0074);
        i_field.drive(0, 1'b1);
        await(0, 8);
        chk(32'(hit), 32'h0000_0001);
        bus(1'b1, aie_pkg::ADDR_ACK, 32'h0000_0001);
        i_field.drive(0, 1'b0);
        await(0, 8);
        chk(32'(hit), 32'h0000_0001);
        bus(1'b1, aie_pkg::ADDR_ACK, 32'h0000_0001);
        // Escalation: the same event recurs on input 0 while its alarm is handled.
        bus(1'b1, aie_pkg::ADDR_CTRL, {base, 16'h0001});
        bus(1'b1, aie_pkg::ADDR_CFG, 32'h0000_2020);
        i_field.drive(0, 1'b1);
        await(0, 8);
        i_field.drive(0, 1'b0);
        repeat (3) @(posedge hclk);
        i_field.drive(0, 1'b1);
        await(1, 8);
        chk(32'(hit), 32'h0000_0001);
        chk(32'(proc_alarm), 32'h0000_0000);
        bus(1'b0, aie_pkg::ADDR_DINFO, 32'h0000_0000);
        first_v = rd_v;
        chk({29'd0, first_v[22], first_v[9:8]}, 32'h0000_0003);
        chk({28'h000_0000, rd_v[3:0]}, {28'h000_0000, aie_pkg::MOD_CLASS});
        i_field.drive(1, 1'b1);
        repeat (4) @(posedge hclk);
        bus(1'b0, aie_pkg::ADDR_DINFO, 32'h0000_0000);
        chk(rd_v, first_v);
        bus(1'b1, aie_pkg::ADDR_ACK, 32'h0000_0002);
        repeat (4) @(posedge hclk);
        bus(1'b0, aie_pkg::ADDR_STAT, 32'h0000_0000);
        chk(32'(rd_v[4]), 32'h0000_0001);
        bus(1'b0, aie_pkg::ADDR_DINFO, 32'h0000_0000);
        chk(32'(rd_v[22]), 32'h0000_0001);
        bus(1'b1, aie_pkg::ADDR_ACK, 32'h0000_0004);
        await(2, 8);
        chk(32'(hit), 32'h0000_0001);
        test_done();
    end
endmodule // alarm_input_event_unit_test

`default_nettype wire
